/* File: common/msc_pkg.sv */
`default_nettype none
package msc_pkg;
    // counter geometry
    localparam int CNT_W = 32;
    localparam int NUM_CMP = 3;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    localparam logic [31:0] CNT_MAX = 32'hFFFF_FFFF;
    // time base: 100 MHz system clock, 16 us symbol period (62.5 kHz)
    localparam int CLK_PERIOD_NS = 10;
    localparam int SYM_PERIOD_NS = 16000;
    localparam int SYM_CYCLES = (SYM_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // backoff slot of 20 symbols
    localparam int BACKOFF_SYMBOLS = 20;
    // byte lane that commits or snapshots a 32-bit register
    localparam logic [1:0] BYTE_LSB = 2'h0;
    localparam logic [7:0] RD_RESET = 8'h00;

    typedef enum logic [2:0] {
        MSC_REG_CNT,
        MSC_REG_SFD_TS,
        MSC_REG_BCN_TS,
        MSC_REG_CMP1,
        MSC_REG_CMP2,
        MSC_REG_CMP3
    } msc_reg_t;

    typedef enum logic {
        MSC_SRC_FAST,
        MSC_SRC_RTC
    } msc_src_t;

    typedef enum logic {
        MSC_UPD_IDLE,
        MSC_UPD_WAIT
    } msc_upd_t;

    // one byte access from the processor
    typedef struct packed {
        logic valid;
        logic write;
        msc_reg_t regSel;
        logic [1:0] byteSel;
        logic [7:0] data;
    } msc_acc_t;

    // one-cycle event pulses
    typedef struct packed {
        logic overflow;
        logic [NUM_CMP-1:0] compare;
        logic backoff;
    } msc_evt_t;
endpackage : msc_pkg
`default_nettype wire

/* File: dv/mac_symbol_counter_core_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// one comparison: counted, a mismatch reported at once
`define CHK(nm, ex, got) begin \
    checks_done++; \
    if ((got) !== (ex)) begin \
        err_total++; \
        $display("BAD %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module mac_symbol_counter_core_bench;
    // short counts keep the run brief; expectations derive from them
    localparam int SYMC = 8;
    localparam int BOS = 4;
    logic clk = 1'b0, rst = 1'b1, slowCrystalInput = 1'b0, trxSleep = 1'b0;
    logic deepSleep = 1'b0, clkSelWrite = 1'b0, clkSelValue = 1'b0, syncReq = 1'b0;
    logic tsEnable = 1'b0, sfdDetect = 1'b0, beaconValid = 1'b0, manualBeaconReq = 1'b0;
    logic [2:0] cmpEnable = 3'h0, cmpRelative = 3'h0;
    msc_pkg::msc_acc_t acc;
    msc_pkg::msc_evt_t events;
    logic [7:0] rdData;
    logic counterClockSourceSelect, counterUpdatePending, wakeReq;
    int err_total = 0, checks_done = 0, ovfN = 0, boN = 0;
    int cmpN [3];
    // model state: expected count and base value
    int unsigned mCnt, mBase, rnd;
    logic [31:0] v, w;

    msc_core #(.SYM_CYCLES(SYMC), .BACKOFF_SYMBOLS(BOS)) uut (
        .clk, .rst, .ce(1'b1), .slowCrystalInput, .trxSleep, .deepSleep, .clkSelWrite,
        .clkSelValue, .syncReq, .tsEnable, .sfdDetect, .beaconValid, .manualBeaconReq,
        .cmpEnable, .cmpRelative, .acc, .rdData, .counterClockSourceSelect,
        .counterUpdatePending, .events, .wakeReq
    );
    msc_cpu_model cpu (.clk, .rdData, .acc);

    always #5 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic sel(input logic s);
        clkSelValue = s;
        clkSelWrite = 1'b1;
        cyc(1);
        clkSelWrite = 1'b0;
        cyc(3);
    endtask : sel
    // one slow crystal period, far slower than a quarter of clk
    task automatic tick;
        slowCrystalInput = 1'b1;
        cyc(4);
        slowCrystalInput = 1'b0;
        cyc(8);
    endtask : tick
    task automatic rdc(input msc_pkg::msc_reg_t r, input logic [31:0] e, input string nm);
        cpu.rd32(r, v);
        `CHK(nm, e, v)
    endtask : rdc
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    // pulses last one cycle, so each is counted once
    always @(posedge clk) begin
        if (!rst) begin
            `CHK("wake", |events, wakeReq)
            ovfN += int'(events.overflow);
            boN += int'(events.backoff);
            for (int i = 0; i < 3; i++) cmpN[i] += int'(events.compare[i]);
        end
    end

    // run needs about 565 cycles; this limit is far beyond it
    initial begin
        #200000;
        err_total++;
        end_of_test();
    end

    initial begin
        void'($urandom(36));
        cmpN = '{0, 0, 0};
        cyc(6);
        rst = 1'b0;
        cyc(1);
        `CHK("rdData", 8'h00, rdData)
        `CHK("select", 1'b0, counterClockSourceSelect)
        `CHK("busy", 1'b0, counterUpdatePending)
        // snapshots 10 symbols apart differ by ten
        cpu.rd32(msc_pkg::MSC_REG_CNT, w);
        cyc(10 * SYMC - 5);
        cpu.rd32(msc_pkg::MSC_REG_CNT, v);
        `CHK("rate", 32'h0000_000A, v - w)
        // absolute hit, relative hit, disabled unit stays quiet
        rnd = $urandom;
        mBase = rnd >> 1;
        cpu.wr32(msc_pkg::MSC_REG_CMP1, mBase + 3);
        cpu.wr32(msc_pkg::MSC_REG_BCN_TS, mBase);
        cpu.wr32(msc_pkg::MSC_REG_CMP2, 32'h0000_0005);
        cpu.wr32(msc_pkg::MSC_REG_CMP3, mBase + 2);
        cmpRelative = 3'h2;
        cmpEnable = 3'h3;
        cmpN = '{0, 0, 0};
        cpu.wr32(msc_pkg::MSC_REG_CNT, mBase);
        cyc(8 * SYMC);
        `CHK("compare", {32'h0, 32'h1, 32'h1}, {cmpN[2], cmpN[1], cmpN[0]})
        rdc(msc_pkg::MSC_REG_CMP1, mBase + 3, "cmp1");
        cmpEnable = 3'h0;
        ovfN = 0;
        cpu.wr32(msc_pkg::MSC_REG_CNT, 32'hFFFF_FFFE);
        cyc(4 * SYMC);
        `CHK("overflow", 1, ovfN)
        // sync restarts the slot: nothing early, one pulse on time
        syncReq = 1'b1;
        cyc(1);
        // cleared after the sync edge so a pulse launched before it is not counted
        boN = 0;
        syncReq = 1'b0;
        cyc(BOS * SYMC - 4);
        `CHK("slot early", 0, boN)
        cyc(7);
        `CHK("slot", 1, boN)
        boN = 0;
        cyc(5 * BOS * SYMC);
        `CHK("slot rate", 5, boN)
        // slow source: a counter load stays pending until the next crystal tick
        sel(1'b1);
        `CHK("slow sel", 1'b1, counterClockSourceSelect)
        rnd = $urandom;
        mCnt = {1'b0, rnd[30:24], 24'hFF_FFFF};
        cpu.wr32(msc_pkg::MSC_REG_CNT, mCnt);
        cyc(2);
        `CHK("busy set", 1'b1, counterUpdatePending)
        tick();
        `CHK("busy clear", 1'b0, counterUpdatePending)
        rdc(msc_pkg::MSC_REG_CNT, mCnt, "load");
        // a tick lands after the low byte read; its carry reaches byte 3 but not the snapshot
        slowCrystalInput = 1'b1;
        cyc(2);
        rdc(msc_pkg::MSC_REG_CNT, mCnt, "snapshot");
        slowCrystalInput = 1'b0;
        cyc(8);
        rdc(msc_pkg::MSC_REG_CNT, mCnt + 1, "carry");
        mCnt += 1;
        tsEnable = 1'b1;
        sfdDetect = 1'b1;
        cyc(1);
        sfdDetect = 1'b0;
        rdc(msc_pkg::MSC_REG_SFD_TS, mCnt, "sfd ts");
        tick();
        manualBeaconReq = 1'b1;
        cyc(1);
        manualBeaconReq = 1'b0;
        rdc(msc_pkg::MSC_REG_BCN_TS, mCnt + 1, "manual ts");
        beaconValid = 1'b1;
        cyc(1);
        beaconValid = 1'b0;
        rdc(msc_pkg::MSC_REG_BCN_TS, mCnt, "beacon ts");
        cpu.wr32(msc_pkg::MSC_REG_SFD_TS, ~mCnt);
        rdc(msc_pkg::MSC_REG_SFD_TS, mCnt, "sfd ro");
        // radio sleep forces slow; a select write meanwhile leaves no trace
        sel(1'b0);
        trxSleep = 1'b1;
        cyc(2);
        `CHK("forced", 1'b1, counterClockSourceSelect)
        sel(1'b1);
        cpu.rd32(msc_pkg::MSC_REG_CNT, w);
        trxSleep = 1'b0;
        cyc(4);
        `CHK("wake sel", 1'b0, counterClockSourceSelect)
        rdc(msc_pkg::MSC_REG_CNT, w, "full period");
        cyc(4);
        rdc(msc_pkg::MSC_REG_CNT, w + 1, "first tick");
        deepSleep = 1'b1;
        cyc(2);
        `CHK("deep sel", 1'b1, counterClockSourceSelect)
        cpu.rd32(msc_pkg::MSC_REG_CNT, w);
        tick();
        rdc(msc_pkg::MSC_REG_CNT, w + 1, "deep count");
        deepSleep = 1'b0;
        end_of_test();
    end
endmodule : mac_symbol_counter_core_bench
`default_nettype wire

/* File: dv/msc_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// processor end of the byte port; requests change only at falling edges
module msc_cpu_model (
    input wire logic clk,
    input wire logic [7:0] rdData,
    output var msc_pkg::msc_acc_t acc
);
    initial acc = '0;
    // released bus: data inverts so a stale byte never looks live
    task automatic idle;
        acc = '{1'b0, 1'b0, msc_pkg::MSC_REG_CNT, 2'h0, ~acc.data};
    endtask : idle
    // low byte first: it freezes the word that the upper bytes come from
    task automatic rd32(input msc_pkg::msc_reg_t r, output logic [31:0] v);
        for (int i = 0; i < 4; i++) begin
            acc = '{1'b1, 1'b0, r, 2'(i), 8'h00};
            @(negedge clk);
            v[8*i +: 8] = rdData;
        end
        idle();
        // one idle edge so a following call never rewrites the bus in this step
        @(negedge clk);
    endtask : rd32
    // upper bytes staged first, the low byte commits
    task automatic wr32(input msc_pkg::msc_reg_t r, input logic [31:0] d);
        for (int i = 3; i >= 0; i--) begin
            acc = '{1'b1, 1'b1, r, 2'(i), d[8*i +: 8]};
            @(negedge clk);
        end
        idle();
        @(negedge clk);
    endtask : wr32
endmodule : msc_cpu_model
`default_nettype wire

/* File: logic/msc_core.sv */
// Notes on behaviour
// - count time base is prescaled fast clock or slow crystal, switchable live
// - in deep-sleep the counter keeps running from the slow crystal
// - a backoff slot counter raises periodic events
// - three compare units, absolute or relative, each pulses on a match
// - every counter event can wake the system
// - timestamps on frame delimiter, valid beacon, or software request
// - synchronise request clears prescaler and backoff slot counter
// - transceiver sleep forces the slow crystal source automatically
// - select bit shows the real source; writes ignored while transceiver sleeps
// - on wake the previously chosen source returns
// - switching slow to fast clears the prescaler for a full first period
// - least significant byte access moves all 32 bits at once
// - reading the low byte snapshots the word; upper bytes come from it
// - writing the low byte commits the staged word to the target; the SFD timestamp is read-only and keeps its value
// - one staging register serves every 32-bit register
// - counter is 32 bits; fast-derived count clock is 62.5 kHz
// - busy flag stays high while a counter load waits
`timescale 1ns/1ps
`default_nettype none
module msc_core #(
    parameter int SYM_CYCLES = msc_pkg::SYM_CYCLES,
    parameter int BACKOFF_SYMBOLS = msc_pkg::BACKOFF_SYMBOLS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic slowCrystalInput,
    input wire logic trxSleep,
    input wire logic deepSleep,
    input wire logic clkSelWrite,
    input wire logic clkSelValue,
    input wire logic syncReq,
    input wire logic tsEnable,
    input wire logic sfdDetect,
    input wire logic beaconValid,
    input wire logic manualBeaconReq,
    input wire logic [msc_pkg::NUM_CMP-1:0] cmpEnable,
    input wire logic [msc_pkg::NUM_CMP-1:0] cmpRelative,
    input wire msc_pkg::msc_acc_t acc,
    output logic [7:0] rdData,
    output logic counterClockSourceSelect,
    output logic counterUpdatePending,
    output msc_pkg::msc_evt_t events,
    output logic wakeReq
);
    localparam int PW = $clog2(SYM_CYCLES);
    localparam int SW = $clog2(BACKOFF_SYMBOLS);
    localparam logic [PW-1:0] PRESC_LAST = PW'(SYM_CYCLES - 1);
    localparam logic [SW-1:0] SLOT_LAST = SW'(BACKOFF_SYMBOLS - 1);

    // byte lane helpers shared by the read and write paths
    function automatic logic [7:0] getByte(input logic [31:0] w, input logic [1:0] i);
        getByte = w[8*i +: 8];
    endfunction : getByte

    function automatic logic [31:0] setByte(input logic [31:0] w, input logic [1:0] i,
                                            input logic [7:0] b);
        logic [31:0] r;
        r = w;
        r[8*i +: 8] = b;
        setByte = r;
    endfunction : setByte

    function automatic logic [31:0] cmpTarget(input logic [31:0] v, input logic [31:0] bcn,
                                              input logic rel);
        cmpTarget = rel ? bcn + v : v;
    endfunction : cmpTarget

    logic rtcLevel;
    logic rtcPrev_q;
    msc_pkg::msc_src_t srcSel_q, srcSel_d, srcEff_q, srcEff_d;
    msc_pkg::msc_upd_t upd_q, upd_d;
    logic [PW-1:0] presc_q, presc_d;
    logic [SW-1:0] slot_q, slot_d;
    logic [31:0] cnt_q, cnt_d, pend_q, pend_d, tmp_q, tmp_d;
    logic [31:0] sfdTs_q, sfdTs_d, bcnTs_q, bcnTs_d;
    logic [31:0] cmp_q [msc_pkg::NUM_CMP];
    logic [31:0] cmp_d [msc_pkg::NUM_CMP];
    logic cntChg_q, cntChg_d;
    logic [7:0] rd_q, rd_d;
    msc_pkg::msc_evt_t evt_q, evt_d;
    logic forceRtc, fastTick, cntTick, switchToFast, rdLsb, wrLsb;
    logic [31:0] regVal, wrWord;

    // slow crystal pin crosses into the system clock domain
    msc_sync3 u_rtcSync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pinIn(slowCrystalInput),
        .level(rtcLevel)
    );

    // source choice and count ticks
    always_comb begin
        forceRtc = trxSleep | deepSleep;
        srcSel_d = srcSel_q;
        if (clkSelWrite && !trxSleep) begin
            srcSel_d = clkSelValue ? msc_pkg::MSC_SRC_RTC : msc_pkg::MSC_SRC_FAST;
        end
        // effective source falls back to the user choice on wake
        srcEff_d = forceRtc ? msc_pkg::MSC_SRC_RTC : srcSel_q;
        switchToFast = (srcEff_q == msc_pkg::MSC_SRC_RTC) &&
                       (srcEff_d == msc_pkg::MSC_SRC_FAST);
        fastTick = 1'b0;
        presc_d = presc_q + PW'(1);
        // prescaler idles at zero on the slow source so a return starts clean
        if (syncReq || switchToFast || srcEff_q == msc_pkg::MSC_SRC_RTC) begin
            presc_d = '0;
        end else if (presc_q == PRESC_LAST) begin
            presc_d = '0;
            fastTick = 1'b1;
        end
        // only the registered source picks the tick, so a switch cannot double count
        cntTick = (srcEff_q == msc_pkg::MSC_SRC_FAST) ? fastTick
                                                       : (rtcLevel & ~rtcPrev_q);
        // backoff slots only run while the transceiver clock runs
        slot_d = slot_q;
        if (syncReq || trxSleep) begin
            slot_d = '0;
        end else if (fastTick) begin
            slot_d = (slot_q == SLOT_LAST) ? '0 : slot_q + SW'(1);
        end
    end

    // register value seen by the low byte read
    always_comb begin
        case (acc.regSel)
            msc_pkg::MSC_REG_CNT: regVal = cnt_q;
            msc_pkg::MSC_REG_SFD_TS: regVal = sfdTs_q;
            msc_pkg::MSC_REG_BCN_TS: regVal = bcnTs_q;
            msc_pkg::MSC_REG_CMP1: regVal = cmp_q[0];
            msc_pkg::MSC_REG_CMP2: regVal = cmp_q[1];
            msc_pkg::MSC_REG_CMP3: regVal = cmp_q[2];
            default: regVal = 32'h0000_0000;
        endcase
    end

    // byte access, counter, timestamps and compare
    always_comb begin
        rdLsb = acc.valid && !acc.write && acc.byteSel == msc_pkg::BYTE_LSB;
        wrLsb = acc.valid && acc.write && acc.byteSel == msc_pkg::BYTE_LSB;
        wrWord = {tmp_q[31:8], acc.data};
        tmp_d = tmp_q;
        rd_d = rd_q;
        if (rdLsb) begin
            tmp_d = regVal;
            rd_d = regVal[7:0];
        end else if (acc.valid && !acc.write) begin
            rd_d = getByte(tmp_q, acc.byteSel);
        end else if (acc.valid && acc.write && !wrLsb) begin
            tmp_d = setByte(tmp_q, acc.byteSel, acc.data);
        end
        // counter: tick, wrap and deferred load
        cnt_d = cnt_q;
        pend_d = pend_q;
        upd_d = upd_q;
        cntChg_d = 1'b0;
        evt_d = '0;
        if (cntTick) begin
            cnt_d = cnt_q + 32'h0000_0001;
            cntChg_d = 1'b1;
            evt_d.overflow = (cnt_q == msc_pkg::CNT_MAX);
        end
        case (upd_q)
            msc_pkg::MSC_UPD_IDLE: begin
                if (wrLsb && acc.regSel == msc_pkg::MSC_REG_CNT) begin
                    if (srcEff_q == msc_pkg::MSC_SRC_FAST) begin
                        cnt_d = wrWord;
                        evt_d.overflow = 1'b0;
                    end else begin
                        // slow source: load waits for the next count edge
                        pend_d = wrWord;
                        upd_d = msc_pkg::MSC_UPD_WAIT;
                    end
                end
            end
            msc_pkg::MSC_UPD_WAIT: begin
                if (cntTick || srcEff_q == msc_pkg::MSC_SRC_FAST) begin
                    cnt_d = pend_q;
                    evt_d.overflow = 1'b0;
                    upd_d = msc_pkg::MSC_UPD_IDLE;
                end
            end
            default: upd_d = msc_pkg::MSC_UPD_IDLE;
        endcase
        // timestamps
        sfdTs_d = sfdTs_q;
        bcnTs_d = bcnTs_q;
        if (tsEnable && sfdDetect) begin
            sfdTs_d = cnt_q;
        end
        if (manualBeaconReq) begin
            bcnTs_d = cnt_q;
        end else if (tsEnable && beaconValid) begin
            bcnTs_d = sfdTs_q;
        end else if (wrLsb && acc.regSel == msc_pkg::MSC_REG_BCN_TS) begin
            bcnTs_d = wrWord;
        end
        // compare units judge the count one cycle after it moves
        for (int i = 0; i < msc_pkg::NUM_CMP; i++) begin
            cmp_d[i] = cmp_q[i];
            if (wrLsb && acc.regSel == msc_pkg::msc_reg_t'(int'(msc_pkg::MSC_REG_CMP1) + i)) begin
                cmp_d[i] = wrWord;
            end
            evt_d.compare[i] = cntChg_q && cmpEnable[i] &&
                               cnt_q == cmpTarget(cmp_q[i], bcnTs_q, cmpRelative[i]);
        end
        evt_d.backoff = fastTick && !trxSleep && !syncReq && slot_q == SLOT_LAST;
    end

    // state registers, frozen while the clock enable is low
    always_ff @(posedge clk) begin
        if (rst) begin
            rtcPrev_q <= 1'b0;
            srcSel_q <= msc_pkg::MSC_SRC_FAST;
            srcEff_q <= msc_pkg::MSC_SRC_FAST;
            upd_q <= msc_pkg::MSC_UPD_IDLE;
            presc_q <= '0;
            slot_q <= '0;
            cnt_q <= msc_pkg::CNT_RESET;
            pend_q <= msc_pkg::CNT_RESET;
            tmp_q <= msc_pkg::CNT_RESET;
            sfdTs_q <= msc_pkg::CNT_RESET;
            bcnTs_q <= msc_pkg::CNT_RESET;
            for (int i = 0; i < msc_pkg::NUM_CMP; i++) begin
                cmp_q[i] <= msc_pkg::CNT_RESET;
            end
            cntChg_q <= 1'b0;
            rd_q <= msc_pkg::RD_RESET;
            evt_q <= '0;
        end else if (ce) begin
            rtcPrev_q <= rtcLevel;
            srcSel_q <= srcSel_d;
            srcEff_q <= srcEff_d;
            upd_q <= upd_d;
            presc_q <= presc_d;
            slot_q <= slot_d;
            cnt_q <= cnt_d;
            pend_q <= pend_d;
            tmp_q <= tmp_d;
            sfdTs_q <= sfdTs_d;
            bcnTs_q <= bcnTs_d;
            cmp_q <= cmp_d;
            cntChg_q <= cntChg_d;
            rd_q <= rd_d;
            evt_q <= evt_d;
        end
    end

    assign rdData = rd_q;
    assign counterClockSourceSelect = (srcEff_q == msc_pkg::MSC_SRC_RTC);
    assign counterUpdatePending = (upd_q == msc_pkg::MSC_UPD_WAIT);
    assign events = evt_q;
    assign wakeReq = |evt_q;

    a_cnt_increment: assert property (@(posedge clk) disable iff (rst)
        ce && cntTick && upd_q == msc_pkg::MSC_UPD_IDLE && !wrLsb
        |=> cnt_q == $past(cnt_q) + 32'h0000_0001) else $error("count did not step");
    a_sleep_forces_rtc: assert property (@(posedge clk) disable iff (rst)
        ce && forceRtc |=> srcEff_q == msc_pkg::MSC_SRC_RTC)
        else $error("sleep kept fast source");
    a_sel_write_ignored: assert property (@(posedge clk) disable iff (rst)
        ce && trxSleep |=> srcSel_q == $past(srcSel_q)) else $error("select changed in sleep");
    a_wake_restores: assert property (@(posedge clk) disable iff (rst)
        ce && !forceRtc |=> srcEff_q == $past(srcSel_q)) else $error("source not restored");
    // six quiet cycles: short enough for the shortest prescaler period that is used
    a_presc_cleared: assert property (@(posedge clk) disable iff (rst)
        ce && switchToFast |=> presc_q == '0 ##1 !fastTick[*6])
        else $error("prescaler not fresh");
    a_sync_clears: assert property (@(posedge clk) disable iff (rst)
        ce && syncReq |=> presc_q == '0 && slot_q == '0) else $error("sync left state");
    a_lsb_snapshot: assert property (@(posedge clk) disable iff (rst)
        ce && rdLsb |=> tmp_q == $past(regVal) && rdData == $past(regVal[7:0]))
        else $error("low byte read missed snapshot");
    a_lsb_commit: assert property (@(posedge clk) disable iff (rst)
        ce && wrLsb && acc.regSel == msc_pkg::MSC_REG_CMP1
        |=> cmp_q[0] == {$past(tmp_q[31:8]), $past(acc.data)}) else $error("commit wrong");
    a_busy_holds: assert property (@(posedge clk) disable iff (rst)
        ce && upd_q == msc_pkg::MSC_UPD_WAIT && !cntTick && srcEff_q == msc_pkg::MSC_SRC_RTC
        |=> counterUpdatePending) else $error("busy dropped early");
    a_cmp_match: assert property (@(posedge clk) disable iff (rst)
        ce && cntChg_q && cmpEnable[0] && cnt_q == cmpTarget(cmp_q[0], bcnTs_q, cmpRelative[0])
        |=> events.compare[0] && wakeReq) else $error("compare match missed");
endmodule : msc_core
`default_nettype wire

/* File: logic/msc_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
module msc_sync3 (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic pinIn,
    output logic level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic level_d;

    // accept a change only once stages two and three agree
    always_comb begin
        level_d = level_q;
        if (s2_q == s3_q) begin
            level_d = s3_q;
        end
    end

    // stage one feeds stage two only
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else if (ce) begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end

    assign level = level_q;
endmodule : msc_sync3
`default_nettype wire
